/* File: adc_ctrl_pkg.sv */
// shared constants and types for the conversion control block
package adc_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock tree
    localparam int unsigned MCLK_HZ  = 10_000_000;        // system clock rate
    localparam int unsigned OSC_HZ   = 1_000_000;         // internal oscillator rate
    localparam int unsigned OSC_DIV  = MCLK_HZ / OSC_HZ;  // mclk cycles per oscillator tick
    localparam int unsigned MOD_DIV  = 4;                 // oscillator ticks per modulator tick
    localparam int unsigned MOD_HZ   = OSC_HZ / MOD_DIV;  // modulator rate, 250 kHz

    ////////////////////////////////////////////////////////////////////////////
    // data rates in samples per second
    localparam int unsigned SPS_128  = 128;
    localparam int unsigned SPS_250  = 250;
    localparam int unsigned SPS_490  = 490;
    localparam int unsigned SPS_920  = 920;
    localparam int unsigned SPS_1600 = 1600;
    localparam int unsigned SPS_2400 = 2400;
    localparam int unsigned SPS_3300 = 3300;

    // modulator ticks per conversion, one per data rate; codes 6 and 7 share TICKS_3300
    localparam int unsigned TICK_W   = 11;
    localparam logic [10:0] TICKS_128  = 11'(MOD_HZ / SPS_128);
    localparam logic [10:0] TICKS_250  = 11'(MOD_HZ / SPS_250);
    localparam logic [10:0] TICKS_490  = 11'(MOD_HZ / SPS_490);
    localparam logic [10:0] TICKS_920  = 11'(MOD_HZ / SPS_920);
    localparam logic [10:0] TICKS_1600 = 11'(MOD_HZ / SPS_1600);
    localparam logic [10:0] TICKS_2400 = 11'(MOD_HZ / SPS_2400);
    localparam logic [10:0] TICKS_3300 = 11'(MOD_HZ / SPS_3300);

    ////////////////////////////////////////////////////////////////////////////
    // result and configuration
    localparam int unsigned RESULT_W          = 12;
    localparam logic        DEF_SINGLE_SHOT   = 1'b1;     // power-up mode: single-shot
    localparam logic [2:0]  DEF_INPUT_SELECT  = 3'h0;     // power-up pair: in0 against in1
    localparam logic [2:0]  DEF_DATA_RATE     = 3'h4;     // power-up rate: 1600 sps

    // input_select codes
    localparam logic [2:0]  SEL_P0_N1 = 3'h0;
    localparam logic [2:0]  SEL_P0_N3 = 3'h1;
    localparam logic [2:0]  SEL_P1_N3 = 3'h2;
    localparam logic [2:0]  SEL_P2_N3 = 3'h3;
    localparam logic [2:0]  SEL_P0_GND = 3'h4;
    localparam logic [2:0]  SEL_P1_GND = 3'h5;
    localparam logic [2:0]  SEL_P2_GND = 3'h6;
    localparam logic [2:0]  SEL_P3_GND = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'b01,
        ST_CONVERT    = 2'b10
    } conv_state_e;

endpackage

/* File: rate_divider.sv */
// divides mclk down to the oscillator tick and the modulator tick
`timescale 1ns/1ps
module rate_divider
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CLK_PER_OSC = OSC_DIV,   // mclk cycles per oscillator tick
    parameter int unsigned OSC_PER_MOD = MOD_DIV    // oscillator ticks per modulator tick
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic ce,
    // restart of the divider chain
    input  wire logic soft_reset,
    // modulator tick, one mclk cycle wide
    output logic      mod_tick
);

    // refuse dividers the 8-bit counters cannot serve, at elaboration
    if (CLK_PER_OSC < 1 || CLK_PER_OSC > 256 || OSC_PER_MOD < 1 || OSC_PER_MOD > 256) begin : bad_divider
        $error("rate_divider: divider out of range");
    end

    // all divider state
    typedef struct packed {
        logic [7:0] osc_count;   // mclk cycles within one oscillator period
        logic [7:0] mod_count;   // oscillator ticks within one modulator period
        logic       tick;        // registered modulator tick
    } div_s;

    div_s cur;                   // registered state
    div_s next_cur;              // next state

    ////////////////////////////////////////////////////////////////////////////
    // next state of both counters
    always_comb begin
        next_cur      = cur;
        next_cur.tick = 1'b0;
        if (soft_reset) begin
            next_cur = '0;
        end else if (cur.osc_count == 8'(CLK_PER_OSC - 1)) begin
            // one oscillator period elapsed
            next_cur.osc_count = 8'h00;
            if (cur.mod_count == 8'(OSC_PER_MOD - 1)) begin
                next_cur.mod_count = 8'h00;
                next_cur.tick      = 1'b1;
            end else begin
                next_cur.mod_count = cur.mod_count + 8'h01;
            end
        end else begin
            next_cur.osc_count = cur.osc_count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign mod_tick = cur.tick;

endmodule

/* File: adc_conversion_control.sv */
// conversion sequencer, input selector and result register of the converter
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CLK_PER_OSC = OSC_DIV,   // mclk cycles per oscillator tick
    parameter int unsigned OSC_PER_MOD = MOD_DIV    // oscillator ticks per modulator tick
) (
    // clock, reset and enable
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                ce,
    // configuration from the serial interface
    input  wire logic                config_write,       // one-cycle write strobe
    input  wire logic                single_shot_in,     // 1 single-shot, 0 continuous
    input  wire logic [2:0]          input_select_in,    // measured pair code
    input  wire logic [2:0]          data_rate_in,       // data rate code
    input  wire logic                start_request,      // one-cycle request for a conversion
    input  wire logic                general_call_reset, // one-cycle general-call reset
    // modulator bitstream from the analog core
    input  wire logic                modulator_bit,
    // configuration readback
    output logic                     single_shot,
    output logic [2:0]               input_select,
    output logic [2:0]               data_rate,
    // conversion status and result
    output logic                     converting,
    output logic                     conversion_done,
    output logic [RESULT_W-1:0]      result,
    // analog controls
    output logic                     modulator_rate,     // modulator sampling tick
    output logic                     analog_in_zero,     // positive input is in0
    output logic                     analog_in_one,      // in1 selected, pos or neg
    output logic                     analog_in_two,      // positive input is in2
    output logic                     analog_in_three,    // in3 selected, pos or neg
    output logic                     neg_is_in1,         // negative input is in1
    output logic                     ground_switch       // negative input tied to ground
);

    ////////////////////////////////////////////////////////////////////////////
    // all block state
    typedef struct packed {
        logic [1:0]          bit_sync;      // two-stage sync of the bitstream
        conv_state_e         state;         // sequencer state
        logic                single_shot;   // mode bit
        logic [2:0]          input_select;  // programmed pair
        logic [2:0]          data_rate;     // programmed rate
        logic [2:0]          active_select; // pair of the running conversion
        logic [2:0]          active_rate;   // rate of the running conversion
        logic [TICK_W-1:0]   tick_count;    // modulator ticks taken so far
        logic [RESULT_W-1:0] accum;         // signed running sum of the bitstream
        logic [RESULT_W-1:0] result;        // last completed result
        logic                done;          // conversion finished this cycle
        logic [3:0]          pos;           // one-hot positive input
        logic                neg_in1;       // negative is in1
        logic                neg_in3;       // negative is in3
        logic                gnd;           // negative tied to ground
    } ctrl_s;

    ctrl_s cur;                             // registered state
    ctrl_s next_cur;                        // next state
    logic  mod_tick;                        // modulator tick from the divider
    logic  soft_reset;                      // restart of the divider chain

    ////////////////////////////////////////////////////////////////////////////
    // conversion length for each data rate code
    function automatic logic [TICK_W-1:0] rate_ticks(input logic [2:0] code);
        logic [TICK_W-1:0] ticks;
        ticks = TICKS_3300;
        case (code)
            3'h0:    ticks = TICKS_128;
            3'h1:    ticks = TICKS_250;
            3'h2:    ticks = TICKS_490;
            3'h3:    ticks = TICKS_920;
            3'h4:    ticks = TICKS_1600;
            3'h5:    ticks = TICKS_2400;
            default: ticks = TICKS_3300;
        endcase
        return ticks;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // modulator tick source
    assign soft_reset = general_call_reset;

    rate_divider #(
        .CLK_PER_OSC (CLK_PER_OSC),
        .OSC_PER_MOD (OSC_PER_MOD)
    ) u_rate_divider (
        .mclk       (mclk),
        .nrst       (nrst),
        .ce         (ce),
        .soft_reset (soft_reset),
        .mod_tick   (mod_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer, accumulator and input selector
    always_comb begin
        logic                start;      // begin a conversion this cycle
        logic [RESULT_W-1:0] sum;        // accumulator after this tick
        start         = 1'b0;
        sum           = cur.accum;
        next_cur      = cur;
        next_cur.done = 1'b0;
        // bitstream crosses in from the analog side
        next_cur.bit_sync = {cur.bit_sync[0], modulator_bit};

        if (general_call_reset) begin
            // state and configuration back to power-up values, result kept
            next_cur.state        = ST_POWER_DOWN;
            next_cur.single_shot  = DEF_SINGLE_SHOT;
            next_cur.input_select = DEF_INPUT_SELECT;
            next_cur.data_rate    = DEF_DATA_RATE;
        end else begin
            // configuration write
            if (config_write) begin
                next_cur.single_shot  = single_shot_in;
                next_cur.input_select = input_select_in;
                next_cur.data_rate    = data_rate_in;
            end
            case (cur.state)
                ST_POWER_DOWN: begin
                    // idle until a request or continuous mode
                    start = !next_cur.single_shot || start_request;
                end
                ST_CONVERT: begin
                    if (mod_tick) begin
                        // +1 for a one, -1 for a zero
                        sum = cur.accum + (cur.bit_sync[1] ? 12'h001 : 12'hFFF);
                        next_cur.accum      = sum;
                        next_cur.tick_count = cur.tick_count + 11'h001;
                        if (next_cur.tick_count == rate_ticks(cur.active_rate)) begin
                            // whole word lands in one edge
                            next_cur.done   = 1'b1;
                            next_cur.result = (cur.active_select[2] && sum[RESULT_W-1])
                                              ? 12'h000 : sum;
                            if (next_cur.single_shot) begin
                                next_cur.state = ST_POWER_DOWN;
                            end else begin
                                start = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    next_cur.state = ST_POWER_DOWN;
                end
            endcase
        end

        // launch a conversion with the pair and rate in force now
        if (start) begin
            next_cur.state         = ST_CONVERT;
            next_cur.active_select = next_cur.input_select;
            next_cur.active_rate   = next_cur.data_rate;
            next_cur.tick_count    = '0;
            next_cur.accum         = '0;
        end

        // switch settings follow the running conversion only
        next_cur.pos     = 4'h0;
        next_cur.neg_in1 = 1'b0;
        next_cur.neg_in3 = 1'b0;
        next_cur.gnd     = 1'b0;
        if (next_cur.state == ST_CONVERT) begin
            case (next_cur.active_select)
                SEL_P0_N1: begin
                    next_cur.pos     = 4'h1;
                    next_cur.neg_in1 = 1'b1;
                end
                SEL_P0_N3: begin
                    next_cur.pos     = 4'h1;
                    next_cur.neg_in3 = 1'b1;
                end
                SEL_P1_N3: begin
                    next_cur.pos     = 4'h2;
                    next_cur.neg_in3 = 1'b1;
                end
                SEL_P2_N3: begin
                    next_cur.pos     = 4'h4;
                    next_cur.neg_in3 = 1'b1;
                end
                default: begin
                    // single-ended: one input against ground
                    next_cur.pos = 4'h1 << next_cur.active_select[1:0];
                    next_cur.gnd = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, defaults and power-down at reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur              <= '0;
            cur.state        <= ST_POWER_DOWN;
            cur.single_shot  <= DEF_SINGLE_SHOT;
            cur.input_select <= DEF_INPUT_SELECT;
            cur.data_rate    <= DEF_DATA_RATE;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from state flip-flops
    assign single_shot     = cur.single_shot;
    assign input_select    = cur.input_select;
    assign data_rate       = cur.data_rate;
    assign converting      = (cur.state == ST_CONVERT);
    assign conversion_done = cur.done;
    assign result          = cur.result;
    assign modulator_rate  = mod_tick;
    assign analog_in_zero  = cur.pos[0];
    assign analog_in_one   = cur.pos[1] | cur.neg_in1;
    assign analog_in_two   = cur.pos[2];
    assign analog_in_three = cur.pos[3] | cur.neg_in3;
    assign neg_is_in1      = cur.neg_in1;
    assign ground_switch   = cur.gnd;

endmodule

/* File: adc_conversion_control_sva.sv */
// assertion checker watching the ports of the conversion control block
`timescale 1ns/1ps
module adc_conversion_control_sva
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CLK_PER_OSC = OSC_DIV,   // mclk cycles per oscillator tick
    parameter int unsigned OSC_PER_MOD = MOD_DIV    // oscillator ticks per modulator tick
) (
    // clock, reset and enable
    input wire logic                mclk,
    input wire logic                nrst,
    input wire logic                ce,
    // requests
    input wire logic                start_request,
    input wire logic                general_call_reset,
    // readback and status
    input wire logic                single_shot,
    input wire logic [2:0]          input_select,
    input wire logic [2:0]          data_rate,
    input wire logic                converting,
    input wire logic                conversion_done,
    input wire logic [RESULT_W-1:0] result,
    // analog controls
    input wire logic                modulator_rate,
    input wire logic                analog_in_zero,
    input wire logic                analog_in_one,
    input wire logic                analog_in_two,
    input wire logic                analog_in_three,
    input wire logic                neg_is_in1,
    input wire logic                ground_switch
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int PER = CLK_PER_OSC * OSC_PER_MOD;  // mclk cycles per modulator tick
    // switches {in0,in1,in2,in3,neg_in1,gnd} per select code, code 0 lowest
    localparam logic [47:0] SW_TAB = {6'h05, 6'h09, 6'h11, 6'h21, 6'h0C, 6'h14, 6'h24, 6'h32};
    // ticks per conversion per rate code, code 0 lowest
    localparam logic [87:0] TK_TAB = {TICKS_3300, TICKS_3300, TICKS_2400, TICKS_1600,
                                      TICKS_920, TICKS_490, TICKS_250, TICKS_128};
    wire logic [5:0] sw_now = {analog_in_zero, analog_in_one, analog_in_two, analog_in_three,
                               neg_is_in1, ground_switch};
    logic [2:0]  sel_lat;    // select of the conversion in flight
    logic [2:0]  rate_lat;   // rate of the conversion in flight
    logic [15:0] cyc;        // cycles since last completion
    logic        cont_prev;  // last completion restarted a conversion
    logic [15:0] tcnt;       // cycles since last modulator tick
    logic        tick_ok;    // tick seen since divider restart

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst || !ce);

    ////////////////////////////////////////////////////////////////////////////
    // tracks the conversion in flight and the tick spacing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_lat   <= 3'h0;
            rate_lat  <= 3'h0;
            cyc       <= 16'h0000;
            cont_prev <= 1'b0;
            tcnt      <= 16'h0000;
            tick_ok   <= 1'b0;
        end else if (ce) begin
            if ($rose(converting) || (conversion_done && converting)) begin
                sel_lat  <= input_select;
                rate_lat <= data_rate;
            end
            cyc       <= conversion_done ? 16'h0001 : cyc + 16'h0001;
            cont_prev <= conversion_done ? converting : cont_prev && !general_call_reset;
            tcnt      <= modulator_rate ? 16'h0000 : tcnt + 16'h0001;
            tick_ok   <= (modulator_rate || tick_ok) && !general_call_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_TICK_PERIOD: assert property (tick_ok |-> tcnt < PER && (!modulator_rate || tcnt == PER - 1))
        else $error("modulator tick spacing wrong");
    AST_DONE_PULSE: assert property (conversion_done |=> !conversion_done)
        else $error("done longer than one cycle");
    AST_RESULT_HOLD: assert property (!conversion_done |-> $stable(result))
        else $error("result changed without completion");
    AST_SINGLE_STOP: assert property (conversion_done && single_shot |-> !converting)
        else $error("single-shot did not stop");
    AST_CONT_RESTART: assert property (conversion_done && !single_shot |-> converting)
        else $error("continuous did not restart");
    AST_CONT_RATE: assert property (conversion_done && cont_prev |->
        cyc == 16'(PER * TK_TAB[rate_lat*11 +: 11]))
        else $error("continuous spacing wrong");
    AST_SWITCH_MAP: assert property (converting |->
        sw_now == SW_TAB[(($rose(converting) || conversion_done) ? input_select : sel_lat)*6 +: 6])
        else $error("switches do not match select");
    AST_SWITCH_IDLE: assert property (!converting |-> sw_now == 6'h00)
        else $error("switches set while idle");
    AST_NO_NEG_SE: assert property (conversion_done && sel_lat[2] |-> !result[RESULT_W-1])
        else $error("negative code on single-ended input");
    AST_START: assert property (start_request && !converting && !general_call_reset |=> converting)
        else $error("request not taken");
    AST_GCR: assert property (general_call_reset |=> !converting && single_shot == DEF_SINGLE_SHOT &&
        input_select == DEF_INPUT_SELECT && data_rate == DEF_DATA_RATE && $stable(result))
        else $error("general-call reset state wrong");
endmodule

/* File: modulator_source.sv */
// bitstream model of the analog modulator core
`timescale 1ns/1ps
module modulator_source (
    // clock
    input  wire logic mclk,
    // level to emit: 1 full positive, 0 full negative
    input  wire logic ones,
    // bitstream to the sequencer
    output logic      modulator_bit
);
    initial modulator_bit = 1'b0;
    // new bit each cycle, unrelated to the tick phase
    always @(posedge mclk) begin
        modulator_bit <= ones;
    end
endmodule

/* File: tb_adc_conversion_control.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import adc_ctrl_pkg::*;
    localparam int unsigned CPO = 1;  // shortened oscillator divide
    // stimulus
    logic        mclk, nrst, ce, config_write, single_shot_in, start_request, general_call_reset, ones;
    logic [2:0]  input_select_in, data_rate_in, rt;
    // observed
    logic        modulator_bit, single_shot, converting, conversion_done, modulator_rate;
    logic        analog_in_zero, analog_in_one, analog_in_two, analog_in_three, neg_is_in1, ground_switch;
    logic [2:0]  input_select, data_rate;
    logic [11:0] result;
    // bookkeeping
    int          n_fail = 0, n_checks = 0, cycles = 0, i, k;
    integer      seed = 4, r;
    int          sps [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};  // samples per second per code

    adc_conversion_control #(.CLK_PER_OSC(CPO), .OSC_PER_MOD(MOD_DIV)) dut (
        .mclk(mclk), .nrst(nrst), .ce(ce), .config_write(config_write), .single_shot_in(single_shot_in),
        .input_select_in(input_select_in), .data_rate_in(data_rate_in), .start_request(start_request),
        .general_call_reset(general_call_reset), .modulator_bit(modulator_bit), .single_shot(single_shot),
        .input_select(input_select), .data_rate(data_rate), .converting(converting),
        .conversion_done(conversion_done), .result(result), .modulator_rate(modulator_rate),
        .analog_in_zero(analog_in_zero), .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
        .analog_in_three(analog_in_three), .neg_is_in1(neg_is_in1), .ground_switch(ground_switch));
    modulator_source partner (.mclk(mclk), .ones(ones), .modulator_bit(modulator_bit));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // expected accumulator for a full-scale input
    function automatic logic [11:0] expect_res(input logic [2:0] s, input logic one, input logic [2:0] c);
        int n;
        n = MOD_HZ / sps[c];
        if (one) return 12'(n);
        return s[2] ? 12'h000 : 12'(-n);
    endfunction
    task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic ss, input logic [2:0] s, input logic [2:0] c);
        @(posedge mclk);
        config_write <= 1'b1;
        single_shot_in <= ss;
        input_select_in <= s;
        data_rate_in <= c;
        @(posedge mclk);
        config_write <= 1'b0;
    endtask
    task automatic go();
        @(posedge mclk);
        start_request <= 1'b1;
        @(posedge mclk);
        start_request <= 1'b0;
    endtask
    task automatic wait_done(input logic [11:0] exp);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (conversion_done !== 1'b1 && k < 9000);
        chk_flag(conversion_done, 1'b1);
        chk_res(result, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, config_write, single_shot_in, start_request, general_call_reset, ones} = 6'h00;
        {ce, input_select_in, data_rate_in} = 7'h40;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1 chk_flag(single_shot, DEF_SINGLE_SHOT);
        chk_res(12'(input_select), 12'(DEF_INPUT_SELECT));
        chk_res(12'(data_rate), 12'(DEF_DATA_RATE));
        chk_flag(converting, 1'b0);
        // every select and rate code, with a stray request mid-run
        for (i = 0; i < 8; i++) begin
            ones <= i[0];
            cfg(1'b1, 3'(i), 3'(i));
            go();
            repeat (3) @(posedge mclk);
            go();
            wait_done(expect_res(3'(i), i[0], 3'(i)));
            repeat (12) @(posedge mclk);
            #1 chk_flag(converting, 1'b0);
        end
        // random single-shots, one frozen by ce mid-run
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            rt = 3'(3 + r[6:4] % 5);
            ones <= r[8];
            cfg(1'b1, 3'(r), rt);
            go();
            if (i == 2) begin
                @(posedge mclk);
                ce <= 1'b0;
                repeat (5) @(posedge mclk);
                ce <= 1'b1;
            end
            wait_done(expect_res(3'(r), r[8], rt));
        end
        // continuous, select changed mid-run, then back to single-shot
        ones <= 1'b0;
        repeat (2) @(posedge mclk);  // new level through the bit synchroniser before the start
        cfg(1'b0, 3'h0, 3'h6);
        wait_done(expect_res(3'h0, 1'b0, 3'h6));
        repeat (20) @(posedge mclk);
        cfg(1'b0, 3'h4, 3'h6);
        wait_done(expect_res(3'h0, 1'b0, 3'h6));
        chk_flag(converting, 1'b1);
        wait_done(expect_res(3'h4, 1'b0, 3'h6));
        cfg(1'b1, 3'h4, 3'h6);
        wait_done(12'h000);
        chk_flag(converting, 1'b0);
        // general-call reset aborts a continuous run, keeps the result
        ones <= 1'b1;
        repeat (2) @(posedge mclk);  // continuous start lands on the write edge, so new level through the bit synchroniser first
        cfg(1'b0, 3'h5, 3'h2);
        wait_done(expect_res(3'h5, 1'b1, 3'h2));
        repeat (30) @(posedge mclk);
        general_call_reset <= 1'b1;
        @(posedge mclk);
        general_call_reset <= 1'b0;
        #1 chk_flag(converting, 1'b0);
        chk_flag(single_shot, DEF_SINGLE_SHOT);
        chk_res(result, expect_res(3'h5, 1'b1, 3'h2));
        repeat (50) @(posedge mclk);
        #1 chk_flag(converting, 1'b0);
        conclude();
    end
endmodule

bind adc_conversion_control adc_conversion_control_sva #(.CLK_PER_OSC(CLK_PER_OSC), .OSC_PER_MOD(OSC_PER_MOD)) chk (
    .mclk(mclk), .nrst(nrst), .ce(ce), .start_request(start_request), .general_call_reset(general_call_reset),
    .single_shot(single_shot), .input_select(input_select), .data_rate(data_rate), .converting(converting),
    .conversion_done(conversion_done), .result(result), .modulator_rate(modulator_rate),
    .analog_in_zero(analog_in_zero), .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
    .analog_in_three(analog_in_three), .neg_is_in1(neg_is_in1), .ground_switch(ground_switch));
